// ### design/obcd_defs.svh
// constants for the option byte configuration decoder
// =====================================================================
// Functional notes
// R01: byte0 bits 4:3 pick supply detect level; 11 turns both detectors off
// R02: programmer keeps reserved bit 2 of byte0 at its default value
// R03: package select is byte1 bit7 high, byte0 bit1 low; 11 is 80-lead
// R04: byte0 bit0 low enables read-out protection, blocking reads and writes; the code drops both blocks while opt_busy is high
// R05: erasing options under protection first erases all user memory
// R06: programmer must not combine read-out protection with low supply detector
// R07: unbonded pads of each 8-pad port reset to input with pull-up
// R08: byte1 bit6 picks reset and halt-exit delay: 0 gives 4096, 1 gives 256
// R09: programmer should choose 4096-cycle delay when a resonator is used
// R10: byte1 bits 5:4 select clock source: resonator, reserved, RC, external
// R11: byte1 bits 3:1 select oscillator range, 1-2 up to 8-16 MHz
// R12: byte1 bit0 low enables the frequency doubler, high disables it
// R13: programmer must not use doubler with RC or external clock source
// R14: programmer enables doubler only with the 2-4 MHz range
// R15: erased or unprogrammed option byte reads as ff
// R16: option bytes reachable only in programming mode, not in memory map
// R17: decoded fields latched during reset and held constant while running
`ifndef OBCD_DEFS_SVH
`define OBCD_DEFS_SVH
`define OBCD_ERASED_BYTE      8'hff
`define OBCD_B0_SUPPLY_HI     4
`define OBCD_B0_SUPPLY_LO     3
`define OBCD_B0_PKG_LOW       1
`define OBCD_B0_PROTECT       0
`define OBCD_B1_PKG_HIGH      7
`define OBCD_B1_RST_LEN       6
`define OBCD_B1_CLK_HI        5
`define OBCD_B1_CLK_LO        4
`define OBCD_B1_RANGE_HI      3
`define OBCD_B1_RANGE_LO      1
`define OBCD_B1_DOUBLER_OFF   0
`define OBCD_RST_LONG_CYCLES  13'd4096
`define OBCD_RST_SHORT_CYCLES 13'd256
`define OBCD_PORT_PADS        8
`define OBCD_ERASE_CYCLES     16'h0100
`endif

// ### design/obcd_pkg.sv
// types for the option byte configuration decoder
package obcd_pkg;
	typedef enum logic [1:0] {
		obcd_supply_high = 2'b00,
		obcd_supply_med  = 2'b01,
		obcd_supply_low  = 2'b10,
		obcd_supply_off  = 2'b11
	} obcd_supply_t;
	typedef enum logic [1:0] {
		obcd_clk_resonator = 2'b00,
		obcd_clk_reserved  = 2'b01,
		obcd_clk_rc        = 2'b10,
		obcd_clk_external  = 2'b11
	} obcd_clk_t;
	typedef enum logic [2:0] {
		range_1_2mhz  = 3'b000,
		range_2_4mhz  = 3'b001,
		range_4_8mhz  = 3'b010,
		range_8_16mhz = 3'b011
	} obcd_range_t;
	typedef enum logic [1:0] {
		obcd_st_idle  = 2'b00,
		obcd_st_erase = 2'b01,
		obcd_st_done  = 2'b10
	} obcd_state_t;
	typedef struct packed {
		obcd_supply_t supply_detect_level;
		logic         low_supply_reset_detector;
		logic         supply_warning_detector;
		logic [1:0]   package_select;
		logic         readout_protect;
		logic         reset_phase_length_select;
		obcd_clk_t    clock_source_select;
		obcd_range_t  oscillator_range_select;
		logic         doubler_enable;
	} obcd_cfg_t;
endpackage : obcd_pkg

// ### design/obcd_top.sv
// option byte store, decoder and reset-time configuration latch
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "obcd_defs.svh"
module obcd_top
	import obcd_pkg::*;
#(
	parameter int          PORTS        = 8,
	parameter logic [12:0] RST_LONG     = `OBCD_RST_LONG_CYCLES,
	parameter logic [12:0] RST_SHORT    = `OBCD_RST_SHORT_CYCLES,
	parameter logic [15:0] ERASE_CYCLES = `OBCD_ERASE_CYCLES
) (
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire logic                    prog_mode_pin,
	input  wire logic                    opt_addr,
	input  wire logic [7:0]              opt_wdata,
	input  wire logic                    opt_wr,
	input  wire logic                    opt_rd,
	input  wire logic                    opt_erase,
	input  wire logic [PORTS*8-1:0]      pad_bonded,
	output logic      [7:0]              opt_rdata,
	output logic                         opt_busy,
	output logic                         user_mem_erase,
	output obcd_cfg_t                    cfg,
	output logic                         mem_read_block,
	output logic                         flash_write_block,
	output logic                         cpu_reset_hold,
	output logic                         halt_exit_busy,
	input  wire logic                    halt_exit_req,
	output logic      [PORTS*8-1:0]      pad_pullup_input
);
	// =================================================================
	// pin synchroniser
	logic       prog_meta;
	logic       prog_sync;
	logic [7:0] opt_byte0 = `OBCD_ERASED_BYTE; // [R15]
	logic [7:0] opt_byte1 = `OBCD_ERASED_BYTE; // [R15]
	obcd_state_t state;
	logic [15:0] erase_cnt;
	logic [12:0] delay_cnt;
	logic        halt_active;
	obcd_cfg_t   next_cfg;
	logic [12:0] phase_len;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prog_meta <= 1'b0;
			prog_sync <= 1'b0;
		end else begin
			prog_meta <= prog_mode_pin;
			prog_sync <= prog_meta;
		end
	end

	// =================================================================
	// option byte storage, non-volatile so not reset
	always_ff @(posedge clk_sys) begin
		if (prog_sync && state == obcd_st_erase
		    && erase_cnt == 16'h0000) begin
			opt_byte0 <= `OBCD_ERASED_BYTE; // [R15] [R05]
			opt_byte1 <= `OBCD_ERASED_BYTE; // [R15]
		end else if (prog_sync && opt_wr && state == obcd_st_idle) begin
			if (opt_addr)
				opt_byte1 <= opt_wdata; // [R16]
			else
				opt_byte0 <= opt_wdata; // [R16]
		end
	end

	// =================================================================
	// erase sequencing: user memory before option bytes when protected
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state     <= obcd_st_idle;
			erase_cnt <= 16'h0000;
		end else begin
			case (state)
				obcd_st_idle: begin
					if (prog_sync && opt_erase) begin
						state <= obcd_st_erase;
						erase_cnt <= opt_byte0[`OBCD_B0_PROTECT]
							? 16'h0000 : ERASE_CYCLES; // [R05]
					end
				end
				obcd_st_erase: begin
					if (erase_cnt == 16'h0000)
						state <= obcd_st_done;
					else
						erase_cnt <= erase_cnt - 16'h0001;
				end
				obcd_st_done: state <= obcd_st_idle;
				default: state <= obcd_st_idle;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			opt_busy       <= 1'b0;
			user_mem_erase <= 1'b0;
		end else begin
			opt_busy <= (state == obcd_st_erase)
				|| (state == obcd_st_idle && prog_sync && opt_erase);
			user_mem_erase <= (state == obcd_st_erase)
				&& (erase_cnt != 16'h0000); // [R05]
		end
	end

	// =================================================================
	// read port, programming mode only
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			opt_rdata <= 8'h00;
		else if (opt_rd && prog_sync)
			opt_rdata <= opt_addr ? opt_byte1 : opt_byte0; // [R16]
		else
			opt_rdata <= 8'h00;
	end

	// =================================================================
	// decode
	always_comb begin
		next_cfg = '0;
		next_cfg.supply_detect_level = obcd_supply_t'(
			opt_byte0[`OBCD_B0_SUPPLY_HI:`OBCD_B0_SUPPLY_LO]); // [R01]
		next_cfg.low_supply_reset_detector =
			opt_byte0[`OBCD_B0_SUPPLY_HI:`OBCD_B0_SUPPLY_LO] != 2'b11;
		next_cfg.supply_warning_detector =
			opt_byte0[`OBCD_B0_SUPPLY_HI:`OBCD_B0_SUPPLY_LO] != 2'b11;
		next_cfg.package_select = {opt_byte1[`OBCD_B1_PKG_HIGH],
			opt_byte0[`OBCD_B0_PKG_LOW]}; // [R03]
		next_cfg.readout_protect = ~opt_byte0[`OBCD_B0_PROTECT]; // [R04]
		next_cfg.reset_phase_length_select =
			opt_byte1[`OBCD_B1_RST_LEN]; // [R08]
		next_cfg.clock_source_select = obcd_clk_t'(
			opt_byte1[`OBCD_B1_CLK_HI:`OBCD_B1_CLK_LO]); // [R10]
		next_cfg.oscillator_range_select = obcd_range_t'(
			opt_byte1[`OBCD_B1_RANGE_HI:`OBCD_B1_RANGE_LO]); // [R11]
		next_cfg.doubler_enable =
			~opt_byte1[`OBCD_B1_DOUBLER_OFF]; // [R12]
	end

	// =================================================================
	// configuration latch: sampled while reset is held
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			cfg <= next_cfg; // [R17]
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mem_read_block    <= 1'b1;
			flash_write_block <= 1'b1;
		end else begin
			mem_read_block    <= cfg.readout_protect && !opt_busy; // [R04]
			flash_write_block <= cfg.readout_protect && !opt_busy; // [R04]
		end
	end

	// =================================================================
	// reset phase and halt exit delay
	assign phase_len = cfg.reset_phase_length_select
		? RST_SHORT : RST_LONG; // [R08]

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			delay_cnt      <= 13'h0000;
			halt_active    <= 1'b0;
			cpu_reset_hold <= 1'b1;
			halt_exit_busy <= 1'b0;
		end else begin
			if (cpu_reset_hold || halt_active) begin
				if (delay_cnt == phase_len - 13'h0001) begin
					cpu_reset_hold <= 1'b0;
					halt_active    <= 1'b0;
					halt_exit_busy <= 1'b0;
					delay_cnt      <= 13'h0000;
				end else begin
					delay_cnt <= delay_cnt + 13'h0001; // [R08]
				end
			end else if (halt_exit_req) begin
				halt_active    <= 1'b1;
				halt_exit_busy <= 1'b1;
			end
		end
	end

	// =================================================================
	// unbonded pads: input with pull-up
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			pad_pullup_input <= '1;
		else
			pad_pullup_input <= ~pad_bonded; // [R07]
	end
endmodule : obcd_top
`default_nettype wire

// ### tb/obcd_checker.sv
// port assertions for the option byte decoder
`timescale 1ns/10ps
`default_nettype none
module obcd_checker
	import obcd_pkg::*;
#(
	parameter int          PORTS     = 8,
	parameter logic [12:0] RST_LONG  = 13'd16,
	parameter logic [12:0] RST_SHORT = 13'd4
) (
	input wire logic               clk_sys,
	input wire logic               sys_rst,
	input wire logic               prog_mode_pin,
	input wire logic               opt_rd,
	input wire logic               opt_erase,
	input wire logic [7:0]         opt_rdata,
	input wire logic               opt_busy,
	input wire logic               user_mem_erase,
	input wire obcd_cfg_t          cfg,
	input wire logic               mem_read_block,
	input wire logic               flash_write_block,
	input wire logic               cpu_reset_hold,
	input wire logic               halt_exit_busy,
	input wire logic [PORTS*8-1:0] pad_pullup_input
);
	// ====
	// helpers and assertions
	logic [2:0]  sh;
	logic [12:0] rc;
	logic [12:0] hc;
	wire logic [12:0] len = cfg.reset_phase_length_select ? RST_SHORT : RST_LONG;
	wire logic prot = cfg.readout_protect;
	always_ff @(posedge clk_sys) sh <= {sh[1:0], prog_mode_pin};
	always_ff @(posedge clk_sys) rc <= sys_rst ? 13'h0 : rc + 13'h1;
	always_ff @(posedge clk_sys) hc <= halt_exit_busy ? hc + 13'h1 : 13'h0;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_ers;
		opt_erase && (&sh) && prog_mode_pin && !opt_busy;
	endsequence
	AST_DET_OFF: assert property (cfg.supply_detect_level == obcd_supply_off
		|-> !cfg.low_supply_reset_detector && !cfg.supply_warning_detector)
		else $error("detectors on with supply field off");
	AST_DET_ON: assert property (cfg.supply_detect_level != obcd_supply_off
		|-> cfg.low_supply_reset_detector && cfg.supply_warning_detector)
		else $error("detectors off with a threshold set");
	AST_PROT: assert property (!opt_busy && !$past(opt_busy) && !$past(sys_rst)
		|-> mem_read_block == prot && flash_write_block == prot)
		else $error("protection blocks differ from option");
	AST_HOLD: assert property (!$past(sys_rst) |-> $stable(cfg))
		else $error("config changed while running");
	AST_PAD: assert property ($past(sys_rst) |-> &pad_pullup_input)
		else $error("pads not pulled up out of reset");
	AST_RST_LEN: assert property ($fell(cpu_reset_hold)
		|-> rc >= len && rc <= len + 13'h1)
		else $error("reset phase length wrong");
	AST_HALT_LEN: assert property ($fell(halt_exit_busy)
		|-> $past(hc) == len - 13'h1)
		else $error("halt exit delay wrong");
	AST_ERASE: assert property (s_ers |=> opt_busy)
		else $error("erase not started");
	AST_UME: assert property (user_mem_erase |-> opt_busy)
		else $error("user erase outside option erase");
	AST_RD_OFF: assert property (opt_rd && !(|sh) && !prog_mode_pin
		|=> opt_rdata == 8'h00)
		else $error("option read outside programming mode");
endmodule : obcd_checker
bind obcd_top obcd_checker #(.PORTS(PORTS), .RST_LONG(RST_LONG),
	.RST_SHORT(RST_SHORT)) i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.prog_mode_pin(prog_mode_pin), .opt_rd(opt_rd), .opt_erase(opt_erase),
	.opt_rdata(opt_rdata), .opt_busy(opt_busy), .cfg(cfg),
	.user_mem_erase(user_mem_erase), .mem_read_block(mem_read_block),
	.flash_write_block(flash_write_block), .cpu_reset_hold(cpu_reset_hold),
	.halt_exit_busy(halt_exit_busy), .pad_pullup_input(pad_pullup_input));
`default_nettype wire

// ### tb/obcd_prog_tool.sv
// programming tool model on the option byte port
`timescale 1ns/10ps
`default_nettype none
module obcd_prog_tool (
	input  wire logic       clk_sys,
	input  wire logic [7:0] opt_rdata,
	output logic            prog_mode_pin,
	output logic            opt_addr,
	output logic [7:0]      opt_wdata,
	output logic            opt_wr,
	output logic            opt_rd,
	output logic            opt_erase
);
	// ====
	// access tasks
	initial {prog_mode_pin, opt_addr, opt_wdata, opt_wr, opt_rd, opt_erase} = '0;
	task automatic mode(input logic on);
		@(posedge clk_sys);
		prog_mode_pin <= on;
		repeat (3) @(posedge clk_sys);
	endtask : mode
	task automatic strobe(input logic [2:0] k, input logic a, input logic [7:0] d);
		@(posedge clk_sys);
		{opt_erase, opt_rd, opt_wr} <= k;
		opt_addr <= a;
		opt_wdata <= d;
		@(posedge clk_sys);
		{opt_erase, opt_rd, opt_wr} <= 3'b000;
		opt_wdata <= ~d;
	endtask : strobe
	task automatic rd(input logic a, output logic [7:0] q);
		strobe(3'b010, a, 8'h00);
		#1;
		q = opt_rdata;
	endtask : rd
	function automatic logic [15:0] legal(input logic [15:0] v);
		logic [15:0] r;
		r = v;
		r[13] = 1'b1;
		r[10] = 1'b1;
		r[3] = 1'b0;
		if (!r[8]) r[12:11] = 2'b11;
		if (r[5:4] == 2'b00) r[6] = 1'b0;
		if (r[5:4] != 2'b00 || r[3:1] != 3'b001) r[0] = 1'b1;
		return r;
	endfunction : legal
endmodule : obcd_prog_tool
`default_nettype wire

// ### tb/obcd_top_tb.sv
// self-checking bench for the option byte decoder
`timescale 1ns/10ps
`default_nettype none
module obcd_top_tb;
	import obcd_pkg::*;
	// ====
	// signals and design
	logic             clk_sys, sys_rst, halt_exit_req, prog_mode_pin, opt_addr;
	logic             opt_wr, opt_rd, opt_erase, opt_busy, user_mem_erase;
	logic             mem_read_block, flash_write_block, cpu_reset_hold;
	logic             halt_exit_busy;
	logic [7:0]       opt_wdata, opt_rdata;
	logic [63:0]      pad_bonded, pad_pullup_input;
	obcd_cfg_t        cfg;
	int               err_count, samples_checked;
	logic             prot;
	obcd_prog_tool i_tool (.clk_sys(clk_sys), .opt_rdata(opt_rdata),
		.prog_mode_pin(prog_mode_pin), .opt_addr(opt_addr), .opt_rd(opt_rd),
		.opt_wdata(opt_wdata), .opt_wr(opt_wr), .opt_erase(opt_erase));
	obcd_top #(.RST_LONG(13'd16), .RST_SHORT(13'd4), .ERASE_CYCLES(16'h0008))
	i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .prog_mode_pin(prog_mode_pin),
		.opt_addr(opt_addr), .opt_wdata(opt_wdata), .opt_wr(opt_wr),
		.opt_rd(opt_rd), .opt_erase(opt_erase), .pad_bonded(pad_bonded),
		.opt_rdata(opt_rdata), .opt_busy(opt_busy), .cfg(cfg),
		.user_mem_erase(user_mem_erase), .mem_read_block(mem_read_block),
		.flash_write_block(flash_write_block), .halt_exit_req(halt_exit_req),
		.cpu_reset_hold(cpu_reset_hold), .halt_exit_busy(halt_exit_busy),
		.pad_pullup_input(pad_pullup_input));
	// ====
	// tasks
	task automatic chk(input string n, input logic [63:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	function automatic obcd_cfg_t exp_cfg(input logic [15:0] v);
		obcd_cfg_t c;
		c.supply_detect_level = obcd_supply_t'(v[12:11]);
		c.low_supply_reset_detector = v[12:11] != 2'b11;
		c.supply_warning_detector = v[12:11] != 2'b11;
		c.package_select = {v[7], v[9]};
		c.readout_protect = !v[8];
		c.reset_phase_length_select = v[6];
		c.clock_source_select = obcd_clk_t'(v[5:4]);
		c.oscillator_range_select = obcd_range_t'(v[3:1]);
		c.doubler_enable = !v[0];
		return c;
	endfunction : exp_cfg
	task automatic prog(input logic [15:0] v);
		logic [7:0] q;
		logic seen;
		int n;
		i_tool.mode(1'b1);
		i_tool.strobe(3'b100, 1'b0, 8'h00);
		seen = 1'b0;
		#1;
		for (n = 0; n < 40 && opt_busy !== 1'b0; n++) begin
			#1;
			seen |= user_mem_erase === 1'b1;
			@(posedge clk_sys);
		end
		chk("busy", 0, opt_busy);
		chk("user_erase", prot, seen);
		i_tool.rd(1'b1, q);
		chk("erased", 8'hff, q);
		i_tool.strobe(3'b001, 1'b0, v[15:8]);
		i_tool.strobe(3'b001, 1'b1, v[7:0]);
		i_tool.rd(1'b0, q);
		chk("byte0", v[15:8], q);
		i_tool.rd(1'b1, q);
		chk("byte1", v[7:0], q);
		i_tool.mode(1'b0);
	endtask : prog
	task automatic boot(input logic [15:0] v);
		logic [12:0] len;
		int n;
		int m;
		len = v[6] ? 13'd4 : 13'd16;
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (n = 1; n < 40; n++) begin
			@(posedge clk_sys);
			#1;
			if (cpu_reset_hold === 1'b0) break;
		end
		chk("phase", 1, n >= len && n <= len + 1);
		chk("cfg", exp_cfg(v), cfg);
		chk("blocks", {2{~v[8]}}, {mem_read_block, flash_write_block});
		chk("pads", ~pad_bonded, pad_pullup_input);
		prot = !v[8];
		halt_exit_req <= 1'b1;
		@(posedge clk_sys);
		halt_exit_req <= 1'b0;
		m = 0;
		repeat (40) begin
			#1;
			m += int'(halt_exit_busy === 1'b1);
			@(posedge clk_sys);
		end
		chk("halt", len, m);
	endtask : boot
	// ====
	// sequence
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		err_count++;
		report_and_stop;
	end
	initial begin
		logic [15:0] v;
		logic [7:0]  q;
		void'($urandom(32'h7093));
		sys_rst = 1'b1;
		halt_exit_req = 1'b0;
		prot = 1'b0;
		pad_bonded = {$urandom, $urandom};
		boot(16'hffff);
		i_tool.strobe(3'b001, 1'b0, 8'h00);
		i_tool.rd(1'b0, q);
		chk("rd_off", 8'h00, q);
		for (int i = 0; i < 8; i++) begin
			v = 16'($urandom);
			v[12:11] = 2'(i);
			v[5:4] = 2'(i);
			v[8] = ~i[2];
			if (i == 4) v[6:0] = 7'h02;
			v = i_tool.legal(v);
			prog(v);
			boot(v);
		end
		prog(16'hffff);
		report_and_stop;
	end
endmodule : obcd_top_tb
`default_nettype wire
